//--- logic/ep_fifo_map.vh
/*
 * Constants for the endpoint data FIFO block: sizes, widths, reset values.
 * Assumes it is included by bare name from the design files.
 */
// Summary of operation
// - tx fifos 1,3,5 stream packets longer than fifo; firmware refills meanwhile.
// - tx flush returns read and write pointers to zero.
// - tx read pointer steps per controller read, wraps, never passes write pointer.
// - tx underrun when empty, more bytes wanted and last-packet bit clear.
// - tx write pointer steps per firmware write and wraps at fifo size.
// - firmware write into a full tx fifo is dropped; firmware checks free count.
// - tx fill level counts bytes loaded but not yet sent.
// - tx warning flag set while fill level is at or below threshold.
// - tx free count equals fifo size minus fill level, shown in status; reads 0 until the first clock after reset.
// - rx fifos 2,4,6 stream long packets; firmware drains during reception.
// - rx flush returns read and write pointers to zero.
// - rx read pointer steps per firmware read, wraps, never passes write pointer.
// - reading an empty rx fifo returns the last byte again, pointer held.
// - rx write pointer steps per controller store and wraps at fifo size.
// - rx overrun when fifo full and another incoming byte must be stored.
// - rx space level counts bytes storable before the next write overruns; reads 0 until the first clock after reset.
// - rx warning flag set while space level is at or below threshold.
// - rx available count equals fifo size minus space level, shown in status, from the first clock after reset.
// - first two fifos of each direction hold 32 bytes, third holds 64.
`ifndef EP_FIFO_MAP_VH
`define EP_FIFO_MAP_VH
`define FIFO_DATA_W 8
`define FIFO_SMALL_AW 5
`define FIFO_LARGE_AW 6
`define FIFO_PTR_RST 7'h00
`define FIFO_DATA_RST 8'h00
`define FIFO_CNT_W 7
`endif

//--- logic/fifo_ram.v
/*
 * Small byte memory for one endpoint FIFO, registered read data.
 * Assumes one clock; read address is sampled every cycle a read is asked.
 */
`timescale 1ns/1ps
`include "ep_fifo_map.vh"
module fifo_ram #(
  parameter AW = `FIFO_SMALL_AW,
  parameter DW = `FIFO_DATA_W
) (
  input wire clk,
  input wire srst,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire rd_en,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data_r
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data holds when no read: an empty read repeats the last byte
  always @(posedge clk) begin
    if (srst) begin
      rd_data_r <= {DW{1'b0}};
    end else if (rd_en) begin
      rd_data_r <= mem[rd_addr];
    end
  end
endmodule // fifo_ram

//--- logic/ep_fifo_chan.v
/*
 * One unidirectional endpoint FIFO: pointers, levels, flags, memory.
 * Assumes synchronous single-cycle read and write strobes.
 */
`timescale 1ns/1ps
`include "ep_fifo_map.vh"
module ep_fifo_chan #(
  parameter AW = `FIFO_SMALL_AW,
  parameter DW = `FIFO_DATA_W,
  parameter TX = 1
) (
  input wire clk,
  input wire srst,
  input wire flush,
  input wire wr_req,
  input wire [DW-1:0] wr_data,
  input wire rd_req,
  input wire last_packet_bit,
  input wire [AW:0] warn_threshold,
  output wire [DW-1:0] rd_data,
  output reg [AW:0] used_r,
  output reg [AW:0] free_r,
  output reg warn_r,
  output reg err_r
);
  localparam [AW:0] SIZE = {1'b1, {AW{1'b0}}};
  localparam [6:0] PTR_RST = `FIFO_PTR_RST;
  reg [AW:0] read_pointer_r;
  reg [AW:0] write_pointer_r;
  wire [AW:0] used_now;
  wire empty;
  wire full;
  wire do_wr;
  wire do_rd;
  wire [AW:0] rp_nxt;
  wire [AW:0] wp_nxt;
  wire [AW:0] used_nxt;
  wire [AW:0] space_nxt;
  wire level_nxt;

  // the wrap bit makes equal addresses with unequal wrap bits mean full
  assign used_now = write_pointer_r - read_pointer_r;
  assign empty = (write_pointer_r == read_pointer_r);
  assign full = (used_now == SIZE);
  assign do_wr = wr_req & ~full & ~flush;
  assign do_rd = rd_req & ~empty & ~flush;
  assign rp_nxt = flush ? PTR_RST[AW:0] :
    (do_rd ? read_pointer_r + 1'b1 : read_pointer_r);
  assign wp_nxt = flush ? PTR_RST[AW:0] :
    (do_wr ? write_pointer_r + 1'b1 : write_pointer_r);
  assign used_nxt = wp_nxt - rp_nxt;
  assign space_nxt = SIZE - used_nxt;
  // tx compares bytes left, rx compares room left
  assign level_nxt = TX ? (used_nxt <= warn_threshold) :
    (space_nxt <= warn_threshold);

  always @(posedge clk) begin
    if (srst) begin
      read_pointer_r <= {(AW+1){1'b0}};
      write_pointer_r <= {(AW+1){1'b0}};
      used_r <= {(AW+1){1'b0}};
      free_r <= SIZE;
      warn_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      read_pointer_r <= rp_nxt;
      write_pointer_r <= wp_nxt;
      used_r <= used_nxt;
      free_r <= space_nxt;
      warn_r <= level_nxt;
      if (TX) begin
        err_r <= rd_req & empty & ~last_packet_bit & ~flush;
      end else begin
        err_r <= wr_req & full & ~flush;
      end
    end
  end

  fifo_ram #(.AW(AW), .DW(DW)) ram (
    .clk(clk),
    .srst(srst),
    .wr_en(do_wr),
    .wr_addr(write_pointer_r[AW-1:0]),
    .wr_data(wr_data),
    .rd_en(do_rd),
    .rd_addr(read_pointer_r[AW-1:0]),
    .rd_data_r(rd_data)
  );
endmodule // ep_fifo_chan

//--- logic/usb_endpoint_data_fifos.v
/*
 * Three transmit and three receive endpoint FIFOs with levels and flags.
 * Assumes firmware and endpoint controller strobes are one-cycle, CLK-sync.
 * Index 0,1,2 of each group: tx endpoints 1,3,5 and rx endpoints 2,4,6.
 */
`timescale 1ns/1ps
`include "ep_fifo_map.vh"
module usb_endpoint_data_fifos #(
  parameter DW = `FIFO_DATA_W,
  parameter SAW = `FIFO_SMALL_AW,
  parameter LAW = `FIFO_LARGE_AW
) (
  input wire CLK,
  input wire SRST,
  input wire [2:0] TX_FLUSH,
  input wire [2:0] TX_FW_WRITE,
  input wire [DW-1:0] TX_FW_DATA,
  input wire [2:0] TX_EPC_READ,
  input wire [2:0] TX_LAST_PACKET_BIT,
  input wire [3*(LAW+1)-1:0] TX_WARNING_THRESHOLD,
  output reg [3*DW-1:0] TX_EPC_DATA,
  output reg [3*(LAW+1)-1:0] TX_FILL_LEVEL,
  output reg [3*(LAW+1)-1:0] TX_FREE_COUNT,
  output reg [2:0] TX_WARNING_FLAG,
  output reg [2:0] TX_UNDERRUN,
  input wire [2:0] RX_FLUSH,
  input wire [2:0] RX_EPC_WRITE,
  input wire [DW-1:0] RX_EPC_DATA,
  input wire [2:0] RX_FW_READ,
  input wire [3*(LAW+1)-1:0] RX_WARNING_THRESHOLD,
  output reg [3*DW-1:0] RX_FW_DATA,
  output reg [3*(LAW+1)-1:0] RX_SPACE_LEVEL,
  output reg [3*(LAW+1)-1:0] RX_AVAIL_COUNT,
  output reg [2:0] RX_WARNING_FLAG,
  output reg [2:0] RX_OVERRUN
);
  localparam CW = LAW + 1;
  wire [3*DW-1:0] tx_data;
  wire [3*CW-1:0] tx_used;
  wire [3*CW-1:0] tx_free;
  wire [2:0] tx_warn;
  wire [2:0] tx_err;
  wire [3*DW-1:0] rx_data;
  wire [3*CW-1:0] rx_used;
  wire [3*CW-1:0] rx_space;
  wire [2:0] rx_warn;
  wire [2:0] rx_err;

  // ----------------------------------------------------------------
  // fifo channels
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : chan
      // the third fifo in each direction is the large one
      localparam AW = (i == 2) ? LAW : SAW;
      localparam [AW:0] SZ = {1'b1, {AW{1'b0}}};
      wire [AW:0] t_used;
      wire [AW:0] t_free;
      wire [AW:0] r_used;
      wire [AW:0] r_space;
      wire [AW:0] t_thr;
      wire [AW:0] r_thr;
      // thresholds above fifo size saturate so the flag stays set
      assign t_thr = (TX_WARNING_THRESHOLD[i*CW +: CW] > SZ) ?
        SZ : TX_WARNING_THRESHOLD[i*CW +: AW+1];
      assign r_thr = (RX_WARNING_THRESHOLD[i*CW +: CW] > SZ) ?
        SZ : RX_WARNING_THRESHOLD[i*CW +: AW+1];

      ep_fifo_chan #(.AW(AW), .DW(DW), .TX(1)) tx_chan (
        .clk(CLK),
        .srst(SRST),
        .flush(TX_FLUSH[i]),
        .wr_req(TX_FW_WRITE[i]),
        .wr_data(TX_FW_DATA),
        .rd_req(TX_EPC_READ[i]),
        .last_packet_bit(TX_LAST_PACKET_BIT[i]),
        .warn_threshold(t_thr),
        .rd_data(tx_data[i*DW +: DW]),
        .used_r(t_used),
        .free_r(t_free),
        .warn_r(tx_warn[i]),
        .err_r(tx_err[i])
      );

      ep_fifo_chan #(.AW(AW), .DW(DW), .TX(0)) rx_chan (
        .clk(CLK),
        .srst(SRST),
        .flush(RX_FLUSH[i]),
        .wr_req(RX_EPC_WRITE[i]),
        .wr_data(RX_EPC_DATA),
        .rd_req(RX_FW_READ[i]),
        .last_packet_bit(1'b0),
        .warn_threshold(r_thr),
        .rd_data(rx_data[i*DW +: DW]),
        .used_r(r_used),
        .free_r(r_space),
        .warn_r(rx_warn[i]),
        .err_r(rx_err[i])
      );

      if (AW == LAW) begin : wide
        assign tx_used[i*CW +: CW] = t_used;
        assign tx_free[i*CW +: CW] = t_free;
        assign rx_used[i*CW +: CW] = r_used;
        assign rx_space[i*CW +: CW] = r_space;
      end else begin : narrow
        assign tx_used[i*CW +: CW] = {{(LAW-AW){1'b0}}, t_used};
        assign tx_free[i*CW +: CW] = {{(LAW-AW){1'b0}}, t_free};
        assign rx_used[i*CW +: CW] = {{(LAW-AW){1'b0}}, r_used};
        assign rx_space[i*CW +: CW] = {{(LAW-AW){1'b0}}, r_space};
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // one extra stage so every port leaves a flip-flop at this level
  always @(posedge CLK) begin
    if (SRST) begin
      TX_EPC_DATA <= {(3*DW){1'b0}};
      TX_FILL_LEVEL <= {(3*CW){1'b0}};
      TX_FREE_COUNT <= {(3*CW){1'b0}};
      TX_WARNING_FLAG <= 3'h0;
      TX_UNDERRUN <= 3'h0;
      RX_FW_DATA <= {(3*DW){1'b0}};
      RX_SPACE_LEVEL <= {(3*CW){1'b0}};
      RX_AVAIL_COUNT <= {(3*CW){1'b0}};
      RX_WARNING_FLAG <= 3'h0;
      RX_OVERRUN <= 3'h0;
    end else begin
      TX_EPC_DATA <= tx_data;
      TX_FILL_LEVEL <= tx_used;
      TX_FREE_COUNT <= tx_free;
      TX_WARNING_FLAG <= tx_warn;
      TX_UNDERRUN <= tx_err;
      RX_FW_DATA <= rx_data;
      RX_SPACE_LEVEL <= rx_space;
      RX_AVAIL_COUNT <= rx_used;
      RX_WARNING_FLAG <= rx_warn;
      RX_OVERRUN <= rx_err;
    end
  end
endmodule // usb_endpoint_data_fifos

//--- tb/ep_fifo_checker.sv
/* assertions on fifo 0 of each group, seen at the block ports.
   assumes the bench holds the warning thresholds constant. */
`timescale 1ns/1ps
module ep_fifo_checker (
  input wire CLK,
  input wire SRST,
  input wire [2:0] TX_FLUSH,
  input wire [2:0] TX_FW_WRITE,
  input wire [2:0] TX_EPC_READ,
  input wire [2:0] TX_LAST_PACKET_BIT,
  input wire [20:0] TX_WARNING_THRESHOLD,
  input wire [20:0] TX_FILL_LEVEL,
  input wire [20:0] TX_FREE_COUNT,
  input wire [2:0] TX_WARNING_FLAG,
  input wire [2:0] TX_UNDERRUN,
  input wire [2:0] RX_FLUSH,
  input wire [2:0] RX_EPC_WRITE,
  input wire [2:0] RX_FW_READ,
  input wire [20:0] RX_SPACE_LEVEL,
  input wire [20:0] RX_AVAIL_COUNT,
  input wire [2:0] RX_OVERRUN
);
  // ----
  // settling
  // ----
  // port stage reads 0 for an edge after reset, so sums wait
  reg [1:0] up_r;
  always @(posedge CLK) begin
    if (SRST) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  wire ok = up_r == 2'h3;
  wire [6:0] tf = TX_FILL_LEVEL[6:0];
  wire [6:0] rs = RX_SPACE_LEVEL[6:0];
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // ----
  // properties
  // ----
  sequence wr0; TX_FW_WRITE[0] && !TX_EPC_READ[0] && !TX_FLUSH[0]; endsequence
  sequence rd0; TX_EPC_READ[0] && !TX_FW_WRITE[0] && !TX_FLUSH[0]; endsequence
  AST_TX_SUM: assert property (
    ok |-> tf + TX_FREE_COUNT[6:0] == 7'h20) else $error("tx sum");
  AST_RX_SUM: assert property (
    ok |-> rs + RX_AVAIL_COUNT[6:0] == 7'h20) else $error("rx sum");
  AST_TX_WR: assert property (
    wr0 ##1 tf < 7'h20 |=> tf == $past(tf) + 7'h01) else $error("tx wr");
  AST_TX_FULL: assert property (
    wr0 ##1 tf == 7'h20 |=> $stable(tf)) else $error("tx full");
  AST_TX_UND: assert property (
    rd0 ##0 !TX_LAST_PACKET_BIT[0] ##1 tf == 7'h00 |=> TX_UNDERRUN[0])
    else $error("tx und");
  AST_TX_FLUSH: assert property (
    TX_FLUSH[0] |-> ##2 tf == 7'h00) else $error("tx flush");
  AST_TX_WARN: assert property (
    ok |-> TX_WARNING_FLAG[0] == (tf <= TX_WARNING_THRESHOLD[6:0]))
    else $error("tx warn");
  AST_RX_OVR: assert property (
    RX_EPC_WRITE[0] && !RX_FW_READ[0] && !RX_FLUSH[0] ##1 rs == 7'h00
    |=> RX_OVERRUN[0]) else $error("rx ovr");
endmodule // ep_fifo_checker
bind usb_endpoint_data_fifos ep_fifo_checker u_chk (.*);

//--- tb/epc_model.sv
/* endpoint controller model: drains tx fifos, stores into rx fifos.
   assumes calls start just after a falling edge of clk. */
`timescale 1ns/1ps
module epc_model (
  input wire clk,
  output reg [2:0] rd = 3'h0,
  output reg [2:0] wr = 3'h0,
  output reg [7:0] wdata = 8'hA5
);
  // one byte per cycle while the strobe stands
  task pull(input integer i, input integer n);
    begin
      rd[i] = 1'b1;
      repeat (n) @(negedge clk);
      rd[i] = 1'b0;
    end
  endtask
  task push(input integer i, input integer n, input [7:0] b);
    integer j;
    begin
      wr[i] = 1'b1;
      for (j = 0; j < n; j = j + 1) begin
        wdata = b + j[7:0];
        @(negedge clk);
      end
      wr[i] = 1'b0;
      // idle bus must not repeat the last byte
      wdata = ~wdata;
    end
  endtask
endmodule // epc_model

//--- tb/usb_endpoint_data_fifos_tb.sv
/* bench for the endpoint fifos: firmware side here, controller model.
   assumes the two-edge port latency of the design. */
`timescale 1ns/1ps
module usb_endpoint_data_fifos_tb;
  reg CLK, SRST;
  reg [2:0] TX_FLUSH, TX_FW_WRITE, TX_LAST_PACKET_BIT, RX_FLUSH, RX_FW_READ;
  reg [7:0] TX_FW_DATA;
  reg [20:0] TX_WARNING_THRESHOLD, RX_WARNING_THRESHOLD;
  wire [2:0] TX_EPC_READ, RX_EPC_WRITE, TX_WARNING_FLAG, TX_UNDERRUN;
  wire [2:0] RX_WARNING_FLAG, RX_OVERRUN;
  wire [7:0] RX_EPC_DATA;
  wire [23:0] TX_EPC_DATA, RX_FW_DATA;
  wire [20:0] TX_FILL_LEVEL, TX_FREE_COUNT, RX_SPACE_LEVEL, RX_AVAIL_COUNT;
  integer errors, checked, k;
  usb_endpoint_data_fifos u_usb_endpoint_data_fifos (.*);
  epc_model u_epc_model (.clk(CLK), .rd(TX_EPC_READ), .wr(RX_EPC_WRITE),
    .wdata(RX_EPC_DATA));
  // ----
  // helpers
  // ----
  task automatic tick(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task chk(input [47:0] nm, input [7:0] e, input [7:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task fw_wr(input integer i, input integer n);
    integer j;
    begin
      TX_FW_WRITE[i] = 1'b1;
      for (j = 0; j < n; j = j + 1) begin
        TX_FW_DATA = j[7:0];
        tick(1);
      end
      TX_FW_WRITE[i] = 1'b0;
    end
  endtask
  task close_out;
    begin
      if (errors == 0 && checked > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  // ----
  // scenarios
  // ----
  task t_big;
    begin
      chk("rxspc", 8'h40, {1'b0, RX_SPACE_LEVEL[20:14]});
      chk("txfr1", 8'h20, {1'b0, TX_FREE_COUNT[13:7]});
      chk("rxsp1", 8'h20, {1'b0, RX_SPACE_LEVEL[13:7]});
      fw_wr(2, 65);
      tick(2);
      chk("txfil", 8'h40, {1'b0, TX_FILL_LEVEL[20:14]});
      TX_FLUSH[2] = 1'b1;
      tick(1);
      TX_FLUSH[2] = 1'b0;
      tick(2);
      chk("txfre", 8'h40, {1'b0, TX_FREE_COUNT[20:14]});
    end
  endtask
  task t_tx;
    begin
      fw_wr(0, 33);
      tick(2);
      chk("txwrn", 8'h00, {7'h00, TX_WARNING_FLAG[0]});
      for (k = 0; k < 32; k = k + 1) begin
        u_epc_model.pull(0, 1);
        tick(2);
        chk("txdat", k[7:0], TX_EPC_DATA[7:0]);
      end
      u_epc_model.pull(0, 1);
      // the underrun pulse stands one cycle only
      tick(1);
      chk("txund", 8'h01, {7'h00, TX_UNDERRUN[0]});
      TX_LAST_PACKET_BIT[0] = 1'b1;
      u_epc_model.pull(0, 1);
      tick(1);
      chk("txund", 8'h00, {7'h00, TX_UNDERRUN[0]});
      fork
        fw_wr(0, 8);
        begin
          tick(2);
          u_epc_model.pull(0, 5);
        end
      join
      tick(2);
      chk("txfil", 8'h03, {1'b0, TX_FILL_LEVEL[6:0]});
      // flush with a write in the same cycle: the write is lost
      TX_FLUSH[0] = 1'b1;
      TX_FW_WRITE[0] = 1'b1;
      tick(1);
      TX_FLUSH[0] = 1'b0;
      TX_FW_WRITE[0] = 1'b0;
      tick(2);
      chk("txfls", 8'h00, {1'b0, TX_FILL_LEVEL[6:0]});
    end
  endtask
  task t_rx;
    begin
      u_epc_model.push(0, 33, 8'h40);
      tick(1);
      chk("rxovr", 8'h01, {7'h00, RX_OVERRUN[0]});
      chk("rxwrn", 8'h01, {7'h00, RX_WARNING_FLAG[0]});
      for (k = 0; k < 33; k = k + 1) begin
        RX_FW_READ[0] = 1'b1;
        tick(1);
        RX_FW_READ[0] = 1'b0;
        tick(2);
        chk("rxdat", 8'h40 + k[7:0] - k[5], RX_FW_DATA[7:0]);
      end
      chk("rxcnt", 8'h00, {1'b0, RX_AVAIL_COUNT[6:0]});
      u_epc_model.push(0, 3, 8'h00);
      RX_FLUSH[0] = 1'b1;
      tick(1);
      RX_FLUSH[0] = 1'b0;
      tick(2);
      chk("rxcnt", 8'h00, {1'b0, RX_AVAIL_COUNT[6:0]});
    end
  endtask
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  initial begin
    #100000;
    errors = errors + 1;
    close_out;
  end
  initial begin
    errors = 0;
    checked = 0;
    SRST = 1'b1;
    {TX_FLUSH, TX_FW_WRITE, TX_LAST_PACKET_BIT, RX_FLUSH, RX_FW_READ} = 15'h0;
    TX_FW_DATA = 8'h00;
    TX_WARNING_THRESHOLD = 21'h000004;
    RX_WARNING_THRESHOLD = 21'h000002;
    tick(16);
    SRST = 1'b0;
    tick(4);
    t_big;
    t_tx;
    t_rx;
    close_out;
  end
endmodule // usb_endpoint_data_fifos_tb
